// ==== rtl/fuse_device.sv ====
// Notes on behaviour
// - Programmed fuse reads 0, unprogrammed 1.
// - Three fuse bytes; extended bits 7:4 read 1.
// - Extended: brown-out level 3:1, test bit 0.
// - High 7 debug, 6 boundary port, 5 serial.
// - High 4 watchdog on, 3 EEPROM preserve.
// - High 2:1 boot size, 0 reset vector.
// - Serial enable fuse untouchable from serial mode.
// - Low 7 divide, 6 clock out, 5:4 start-up.
// - Low 3:0 clock source, default internal RC.
// - Chip erase leaves fuses unchanged.
// - Fuse writes refused once lock bit one programmed.
// - Fuses latched on entering programming mode.
// - EEPROM preserve fuse takes effect immediately.
// - Fuses latched at power-up in normal mode.
// - Three signature bytes, readable even when locked.
// - Calibration byte loaded into register at reset.
// - Crystal pulse performs selected load action.
// - Write or output-enable pulse runs loaded command.
// - Ready/busy low during operation, high otherwise.
// - Device drives data only while output-enable low.
// - Byte select one picks low or high byte.
// - Byte select two and page load strobe.
// - Action codes: address, data, command, idle.
// - Command decoder codes for erase, writes, reads.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "fuse_port_cfg.svh"
module fuse_device import fuse_port_pkg::*; #(
   parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary value
   parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary value
   parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary value
   parameter logic [7:0] CAL_BYTE = 8'h80,
   parameter int BUSY_CYCLES = `BUSY_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   fuse_port_if.device pins,
   input wire logic progMode,
   input wire logic serialMode,
   input wire logic serialFuseWrite,
   input wire logic [1:0] serialFuseSel,
   input wire logic [7:0] serialFuseData,
   output logic [7:0] serialFuseRead,
   output logic [7:0] fuseExtActive,
   output logic [7:0] fuseHighActive,
   output logic [7:0] fuseLowActive,
   output logic [7:0] oscillatorCalibrationRegister,
   output logic [7:0] lockBits
);

   // ************************************************
   // Pin synchronisers
   // ************************************************
   logic [7:0] ctlSync;
   logic [7:0] dataSync;
   logic xtalS;
   logic act1S;
   logic act0S;
   logic bs1S;
   logic bs2S;
   logic pageS;
   logic wrS;
   logic oeS;

   fuse_sync #(.W(8), .RESET_VAL(8'h03)) ctlSyncInst (
      .mclk(mclk),
      .reset(reset),
      .din({pins.crystalInputPin, pins.actionSelectBit1,
            pins.actionSelectBit0, pins.byteSelectOne,
            pins.byteSelectTwo, pins.pageLoadStrobe,
            pins.writeStrobeN, pins.outputEnableN}),
      .dout(ctlSync)
   );

   fuse_sync #(.W(8), .RESET_VAL(8'hFF)) dataSyncInst (
      .mclk(mclk),
      .reset(reset),
      .din(pins.dataBus),
      .dout(dataSync)
   );

   assign {xtalS, act1S, act0S, bs1S, bs2S, pageS, wrS, oeS} = ctlSync;

   // ************************************************
   // Edge detection
   // ************************************************
   logic xtalPrev_r;
   logic wrPrev_r;
   logic xtalRise;
   logic wrFall;

   always_ff @(posedge mclk) begin
      if (reset) begin
         xtalPrev_r <= 1'b0;
         wrPrev_r <= 1'b1;
      end else begin
         xtalPrev_r <= xtalS;
         wrPrev_r <= wrS;
      end
   end

   assign xtalRise = xtalS & ~xtalPrev_r;
   assign wrFall = ~wrS & wrPrev_r;

   // ************************************************
   // Address, data and command loading
   // ************************************************
   logic [7:0] addrLow_r;
   logic [7:0] addrHigh_r;
   logic [7:0] dataLow_r;
   logic [7:0] dataHigh_r;
   logic [7:0] cmd_r;

   always_ff @(posedge mclk) begin
      if (reset) begin
         addrLow_r <= 8'h00;
         addrHigh_r <= 8'h00;
         dataLow_r <= 8'h00;
         dataHigh_r <= 8'h00;
         cmd_r <= 8'h00;
      end else if (xtalRise && progMode) begin
         case ({act1S, act0S})
            `ACT_ADDR: begin
               if (bs1S) begin
                  addrHigh_r <= dataSync;
               end else begin
                  addrLow_r <= dataSync;
               end
            end
            `ACT_DATA: begin
               if (bs1S) begin
                  dataHigh_r <= dataSync;
               end else begin
                  dataLow_r <= dataSync;
               end
            end
            `ACT_CMD: begin
               cmd_r <= dataSync;
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************
   // Command decode and busy timer
   // ************************************************
   logic isWriteCmd;
   logic startOp;
   logic ready_r;
   logic [15:0] busyCnt_r;
   fuse_sel_t selNow;
   logic fuseUnlocked;

   always_comb begin
      case (cmd_r)
         `CMD_ERASE, `CMD_WR_FUSE, `CMD_WR_LOCK,
         `CMD_WR_FLASH, `CMD_WR_EEPROM: begin
            isWriteCmd = 1'b1;
         end
         default: begin
            isWriteCmd = 1'b0;
         end
      endcase
   end

   assign fuseUnlocked = lockBits[`LOCK_ONE_BIT];
   assign selNow = fuse_sel_t'({bs2S, bs1S});
   assign startOp = wrFall && progMode && ready_r && isWriteCmd
      && !(cmd_r == `CMD_WR_FUSE && !fuseUnlocked);

   always_ff @(posedge mclk) begin
      if (reset) begin
         busyCnt_r <= 16'h0000;
         ready_r <= 1'b1;
      end else if (startOp) begin
         busyCnt_r <= 16'(BUSY_CYCLES);
         ready_r <= 1'b0;
      end else begin
         if (busyCnt_r != 16'h0000) begin
            busyCnt_r <= busyCnt_r - 16'h0001;
         end
         ready_r <= (busyCnt_r <= 16'h0001);
      end
   end

   assign pins.readyBusyOut = ready_r;

   // ************************************************
   // Fuse and lock store
   // ************************************************
   logic [7:0] fuseExt_r;
   logic [7:0] fuseHigh_r;
   logic [7:0] fuseLow_r;
   logic [7:0] serialKeep;

   assign serialKeep = 8'h01 << `HIGH_SERIAL_EN_BIT;

   always_ff @(posedge mclk) begin
      if (reset) begin
         fuseExt_r <= `FUSE_EXT_RESET;
         fuseHigh_r <= `FUSE_HIGH_RESET;
         fuseLow_r <= `FUSE_LOW_RESET;
      end else if (startOp && cmd_r == `CMD_WR_FUSE) begin
         case (selNow)
            SEL_LOW: fuseLow_r <= dataLow_r;
            SEL_HIGH: fuseHigh_r <= dataLow_r;
            SEL_EXT: fuseExt_r <= dataLow_r | `EXT_UNUSED_MASK;
            default: begin
            end
         endcase
      end else if (serialFuseWrite && serialMode && fuseUnlocked) begin
         case (fuse_sel_t'(serialFuseSel))
            SEL_LOW: fuseLow_r <= serialFuseData;
            SEL_HIGH: fuseHigh_r <= (serialFuseData & ~serialKeep)
               | (fuseHigh_r & serialKeep);
            SEL_EXT: fuseExt_r <= serialFuseData | `EXT_UNUSED_MASK;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         lockBits <= `LOCK_RESET;
      end else if (startOp && cmd_r == `CMD_ERASE) begin
         lockBits <= `LOCK_RESET;
      end else if (startOp && cmd_r == `CMD_WR_LOCK) begin
         lockBits <= lockBits & dataLow_r;
      end
   end

   // ************************************************
   // Active fuse latching
   // ************************************************
   logic progActive;
   logic progPrev_r;
   logic latchPend_r;

   assign progActive = progMode | serialMode;

   always_ff @(posedge mclk) begin
      if (reset) begin
         progPrev_r <= 1'b0;
         latchPend_r <= 1'b1;
      end else begin
         progPrev_r <= progActive;
         latchPend_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         fuseExtActive <= `FUSE_EXT_RESET;
         fuseHighActive <= `FUSE_HIGH_RESET;
         fuseLowActive <= `FUSE_LOW_RESET;
      end else if (latchPend_r || progActive != progPrev_r) begin
         fuseExtActive <= fuseExt_r;
         fuseHighActive <= fuseHigh_r;
         fuseLowActive <= fuseLow_r;
      end else if (progActive) begin
         fuseHighActive[`HIGH_EEPROM_KEEP_BIT] <=
            fuseHigh_r[`HIGH_EEPROM_KEEP_BIT];
      end
   end

   // ************************************************
   // Calibration register
   // ************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         oscillatorCalibrationRegister <= CAL_BYTE;
      end
   end

   // ************************************************
   // Read path and data bus drive
   // ************************************************
   logic [7:0] readData;
   logic [7:0] sigByte;

   always_comb begin
      case (addrLow_r[1:0])
         2'h0: sigByte = SIG_BYTE0;
         2'h1: sigByte = SIG_BYTE1;
         2'h2: sigByte = SIG_BYTE2;
         default: sigByte = 8'hFF;
      endcase
   end

   always_comb begin
      case (cmd_r)
         `CMD_RD_SIG: readData = bs1S ? CAL_BYTE : sigByte;
         `CMD_RD_FUSE: begin
            case (selNow)
               SEL_LOW: readData = fuseLow_r;
               SEL_LOCK: readData = lockBits;
               SEL_EXT: readData = fuseExt_r | `EXT_UNUSED_MASK;
               default: readData = fuseHigh_r;
            endcase
         end
         default: readData = 8'hFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pins.dataDev <= 8'hFF;
         pins.dataDevOe <= 1'b0;
      end else begin
         pins.dataDev <= readData;
         pins.dataDevOe <= progMode && !oeS;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         serialFuseRead <= 8'hFF;
      end else begin
         case (fuse_sel_t'(serialFuseSel))
            SEL_LOW: serialFuseRead <= fuseLow_r;
            SEL_LOCK: serialFuseRead <= lockBits;
            SEL_EXT: serialFuseRead <= fuseExt_r;
            default: serialFuseRead <= fuseHigh_r | serialKeep;
         endcase
      end
   end

endmodule

// ==== include/fuse_port_cfg.svh ====
`ifndef FUSE_PORT_CFG_SVH
`define FUSE_PORT_CFG_SVH

// ************************************************
// Fuse reset values and field positions
// ************************************************
`define FUSE_EXT_RESET 8'hFF
`define FUSE_HIGH_RESET 8'h99
`define FUSE_LOW_RESET 8'h62
`define LOCK_RESET 8'hFF
`define EXT_UNUSED_MASK 8'hF0
`define HIGH_SERIAL_EN_BIT 5
`define HIGH_EEPROM_KEEP_BIT 3
`define LOCK_ONE_BIT 0

// ************************************************
// Action select and command codes
// ************************************************
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3
`define CMD_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EEPROM 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EEPROM 8'h03

// ************************************************
// Timing
// ************************************************
`define CLK_PERIOD_NS 10
`define STROBE_NS 250
`define STROBE_CYCLES ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_CYCLES 200

// ************************************************
// Programmer register map
// ************************************************
`define REG_ADDR_W 8
`define REG_OP_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define OP_DATA_LSB 0
`define OP_ACT_LSB 8
`define OP_BS1_BIT 10
`define OP_BS2_BIT 11
`define OP_KIND_LSB 12
`define OP_XTAL 3'h0
`define OP_WRITE 3'h1
`define OP_READ 3'h2
`define OP_PAGE 3'h3
`define ST_BUSY_BIT 0
`define ST_READY_BIT 1
`define ST_RDATA_LSB 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== include/fuse_port_pkg.sv ====
package fuse_port_pkg;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [1:0] {
      SEL_LOW,
      SEL_LOCK,
      SEL_EXT,
      SEL_HIGH
   } fuse_sel_t;

   typedef enum logic [1:0] {
      PRG_IDLE,
      PRG_SETUP,
      PRG_STROBE,
      PRG_HOLD
   } prog_state_t;

endpackage

// ==== include/fuse_port_if.sv ====
`timescale 1ns/1ps
interface fuse_port_if;
   logic crystalInputPin;
   logic actionSelectBit0;
   logic actionSelectBit1;
   logic byteSelectOne;
   logic byteSelectTwo;
   logic pageLoadStrobe;
   logic writeStrobeN;
   logic outputEnableN;
   logic [7:0] dataProg;
   logic dataProgOe;
   logic [7:0] dataDev;
   logic dataDevOe;
   logic readyBusyOut;
   logic [7:0] dataBus;

   // Bus level, pulled high when nobody drives
   assign dataBus = dataDevOe ? dataDev : (dataProgOe ? dataProg : 8'hFF);

   modport device(
      input crystalInputPin,
      input actionSelectBit0,
      input actionSelectBit1,
      input byteSelectOne,
      input byteSelectTwo,
      input pageLoadStrobe,
      input writeStrobeN,
      input outputEnableN,
      input dataBus,
      output dataDev,
      output dataDevOe,
      output readyBusyOut
   );

   modport programmer(
      output crystalInputPin,
      output actionSelectBit0,
      output actionSelectBit1,
      output byteSelectOne,
      output byteSelectTwo,
      output pageLoadStrobe,
      output writeStrobeN,
      output outputEnableN,
      output dataProg,
      output dataProgOe,
      input dataBus,
      input readyBusyOut
   );
endinterface

// ==== rtl/fuse_sync.sv ====
`timescale 1ns/1ps
module fuse_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1_r;

   // ************************************************
   // Two flip-flop synchroniser
   // ************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         stage1_r <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         stage1_r <= din;
         dout <= stage1_r;
      end
   end
endmodule

// ==== rtl/fuse_programmer.sv ====
`timescale 1ns/1ps
`include "fuse_port_cfg.svh"
module fuse_programmer import fuse_port_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [`REG_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`REG_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   fuse_port_if.programmer pins
);
   localparam int STROBE_CYCLES = `STROBE_CYCLES;

   // ************************************************
   // Pin input synchroniser
   // ************************************************
   logic [8:0] inSync;

   fuse_sync #(.W(9), .RESET_VAL(9'h1FF)) inSyncInst (
      .mclk(mclk),
      .reset(reset),
      .din({pins.readyBusyOut, pins.dataBus}),
      .dout(inSync)
   );

   // ************************************************
   // AXI4-Lite write channel
   // ************************************************
   logic awHeld_r;
   logic wHeld_r;
   logic [`REG_ADDR_W-1:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic doWrite;
   logic startSeq;
   prog_state_t state_r;

   assign awready = !awHeld_r && !bvalid;
   assign wready = !wHeld_r && !bvalid;
   assign doWrite = awHeld_r && wHeld_r;
   assign startSeq = doWrite && awAddr_r == `REG_OP_OFS
      && wStrb_r[1:0] == 2'h3 && state_r == PRG_IDLE;

   always_ff @(posedge mclk) begin
      if (reset) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= startSeq ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ************************************************
   // Pin sequencer
   // ************************************************
   logic [7:0] cnt_r;
   logic [2:0] kind_r;
   logic [7:0] readData_r;

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= PRG_IDLE;
         cnt_r <= 8'h00;
         kind_r <= `OP_XTAL;
         readData_r <= 8'h00;
         pins.crystalInputPin <= 1'b0;
         pins.actionSelectBit1 <= 1'b1;
         pins.actionSelectBit0 <= 1'b1;
         pins.byteSelectOne <= 1'b0;
         pins.byteSelectTwo <= 1'b0;
         pins.pageLoadStrobe <= 1'b0;
         pins.writeStrobeN <= 1'b1;
         pins.outputEnableN <= 1'b1;
         pins.dataProg <= 8'h00;
         pins.dataProgOe <= 1'b1;
      end else begin
         case (state_r)
            PRG_IDLE: begin
               pins.dataProgOe <= 1'b1;
               if (startSeq) begin
                  kind_r <= wData_r[`OP_KIND_LSB +: 3];
                  {pins.actionSelectBit1, pins.actionSelectBit0} <=
                     wData_r[`OP_ACT_LSB +: 2];
                  pins.byteSelectOne <= wData_r[`OP_BS1_BIT];
                  pins.byteSelectTwo <= wData_r[`OP_BS2_BIT];
                  pins.dataProg <= wData_r[`OP_DATA_LSB +: 8];
                  pins.dataProgOe <= wData_r[`OP_KIND_LSB +: 3]
                     != `OP_READ;
                  cnt_r <= 8'(STROBE_CYCLES - 1);
                  state_r <= PRG_SETUP;
               end
            end
            PRG_SETUP: begin
               if (cnt_r == 8'h00) begin
                  case (kind_r)
                     `OP_XTAL: pins.crystalInputPin <= 1'b1;
                     `OP_WRITE: pins.writeStrobeN <= 1'b0;
                     `OP_READ: pins.outputEnableN <= 1'b0;
                     default: pins.pageLoadStrobe <= 1'b1;
                  endcase
                  cnt_r <= 8'(STROBE_CYCLES - 1);
                  state_r <= PRG_STROBE;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            PRG_STROBE: begin
               if (cnt_r == 8'h00) begin
                  pins.crystalInputPin <= 1'b0;
                  pins.writeStrobeN <= 1'b1;
                  pins.outputEnableN <= 1'b1;
                  pins.pageLoadStrobe <= 1'b0;
                  if (kind_r == `OP_READ) begin
                     readData_r <= inSync[7:0];
                  end
                  cnt_r <= 8'(STROBE_CYCLES - 1);
                  state_r <= PRG_HOLD;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            PRG_HOLD: begin
               if (cnt_r == 8'h00) begin
                  state_r <= PRG_IDLE;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            default: begin
               state_r <= PRG_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // AXI4-Lite read channel
   // ************************************************
   assign arready = !rvalid;

   always_ff @(posedge mclk) begin
      if (reset) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
         if (araddr == `REG_STATUS_OFS) begin
            rdata[`ST_BUSY_BIT] <= state_r != PRG_IDLE;
            rdata[`ST_READY_BIT] <= inSync[8];
            rdata[`ST_RDATA_LSB +: 8] <= readData_r;
         end else if (araddr != `REG_OP_OFS) begin
            rresp <= `RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule

// ==== bench/fuse_port_props.sv ====
`timescale 1ns/1ps
module fuse_port_props #(
   parameter int BUSY_CYCLES = 200
) (
   input logic mclk,
   input logic reset,
   input logic crystalInputPin,
   input logic actionSelectBit0,
   input logic actionSelectBit1,
   input logic writeStrobeN,
   input logic outputEnableN,
   input logic dataDevOe,
   input logic readyBusyOut
);
   localparam int BusyLo = BUSY_CYCLES - 2;
   localparam int BusyHi = BUSY_CYCLES + 2;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence busyStart;
      $fell(readyBusyOut);
   endsequence
   sequence busyHold;
      (!readyBusyOut)[*8];
   endsequence
   AST_BUSY_CAUSE: assert property (
      busyStart |-> !$past(writeStrobeN, 3))
      else $error("busy without write strobe");
   AST_BUSY_HOLD: assert property (busyStart |-> busyHold)
      else $error("busy too short");
   AST_BUSY_END: assert property (
      busyStart |-> ##[BusyLo:BusyHi] readyBusyOut)
      else $error("busy length wrong");
   AST_OE_RELEASE: assert property (outputEnableN[*8] |-> !dataDevOe)
      else $error("device drives without output enable");
   AST_DRIVE_CAUSE: assert property (
      $rose(dataDevOe) |-> !$past(outputEnableN, 2))
      else $error("drive not caused by output enable");
   AST_READ_STRETCH: assert property (
      $rose(dataDevOe) |-> dataDevOe[*8])
      else $error("read drive too short");
   AST_XTAL_WIDTH: assert property (
      $rose(crystalInputPin) |-> crystalInputPin[*8])
      else $error("crystal pulse too short");
   AST_ACT_HELD: assert property (crystalInputPin |->
      $stable({actionSelectBit1, actionSelectBit0}))
      else $error("action select moved in pulse");
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "fuse_port_cfg.svh"
module tb;
   localparam int BUSY = 100;
   // Arbitrary signature values
   localparam logic [7:0] SIG [3] = '{8'h3A, 8'h4B, 8'h5C};
   logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, progMode = 1, serialMode = 0;
   logic serialFuseWrite = 0;
   logic [1:0] sSel = 0, bresp, rresp;
   logic [7:0] awaddr = 0, araddr = 0, sData = 0;
   logic [7:0] serRd, highAct, lowAct, osc, locks, extAct;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] wdata = 0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   int mismatches = 0, checks = 0, cyc = 0;
   fuse_port_if pif();
   fuse_device #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]),
      .CAL_BYTE(8'h80), .BUSY_CYCLES(BUSY)) fuse_device_i (.mclk, .reset,
      .pins(pif.device), .progMode, .serialMode, .serialFuseWrite,
      .serialFuseSel(sSel), .serialFuseData(sData), .serialFuseRead(serRd),
      .fuseExtActive(extAct), .fuseHighActive(highAct), .fuseLowActive(lowAct),
      .oscillatorCalibrationRegister(osc), .lockBits(locks));
   fuse_programmer fuse_programmer_i (.mclk, .reset, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .pins(pif.programmer));
   fuse_port_props #(.BUSY_CYCLES(BUSY)) fuse_port_props_i (.mclk, .reset,
      .crystalInputPin(pif.crystalInputPin),
      .actionSelectBit0(pif.actionSelectBit0),
      .actionSelectBit1(pif.actionSelectBit1),
      .writeStrobeN(pif.writeStrobeN), .outputEnableN(pif.outputEnableN),
      .dataDevOe(pif.dataDevOe), .readyBusyOut(pif.readyBusyOut));
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task automatic cmp(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic b, ha, hw;
      b = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(negedge mclk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge mclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic b, h;
      b = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!b) begin
         @(negedge mclk);
         h = arvalid && arready;
         b = rvalid;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (h) arvalid <= 1'b0;
      end
   endtask
   task automatic op(input logic [2:0] k, input logic [1:0] a,
      input logic b1, b2, input logic [7:0] d);
      logic [1:0] r;
      logic [31:0] s;
      axw(`REG_OP_OFS, {17'h0, k, b2, b1, a, d}, r);
      cmp(r, `RESP_OKAY);
      do axr(`REG_STATUS_OFS, s, r); while (s[0]);
   endtask
   task automatic ld(input logic [1:0] a, input logic b1, input logic [7:0] d);
      op(`OP_XTAL, a, b1, 1'b0, d);
   endtask
   task automatic rdb(input logic b1, b2, input logic [7:0] e);
      logic [1:0] r;
      logic [31:0] s;
      op(`OP_READ, `ACT_IDLE, b1, b2, 8'h00);
      axr(`REG_STATUS_OFS, s, r);
      cmp(s[15:8], e);
   endtask
   task automatic wr(input logic b1, b2, eb);
      logic [1:0] r;
      logic [31:0] s;
      op(`OP_WRITE, `ACT_IDLE, b1, b2, 8'h00);
      axr(`REG_STATUS_OFS, s, r);
      cmp(s[1], !eb);
      while (!s[1]) axr(`REG_STATUS_OFS, s, r);
   endtask
   initial begin
      logic [1:0] r;
      logic [31:0] s;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      axw(8'h08, 32'h0, r);
      cmp(r, `RESP_SLVERR);
      wstrb <= 4'h1;
      axw(`REG_OP_OFS, 32'h0, r);
      cmp(r, `RESP_SLVERR);
      wstrb <= 4'hF;
      axr(8'h08, s, r);
      cmp(r, `RESP_SLVERR);
      ld(`ACT_CMD, 0, `CMD_RD_FUSE);
      rdb(0, 0, 8'h62);
      rdb(1, 1, 8'h99);
      rdb(0, 1, 8'hFF);
      rdb(1, 0, 8'hFF);
      ld(`ACT_CMD, 0, `CMD_RD_SIG);
      for (int i = 0; i < 3; i++) begin
         ld(`ACT_ADDR, 0, i[7:0]);
         rdb(0, 0, SIG[i]);
      end
      ld(`ACT_ADDR, 0, 8'h00);
      rdb(1, 0, 8'h80);
      cmp(osc, 8'h80);
      ld(`ACT_CMD, 0, `CMD_WR_FUSE);
      ld(`ACT_DATA, 0, 8'h11);
      wr(1, 1, 1);
      ld(`ACT_DATA, 0, 8'h60);
      wr(0, 0, 1);
      ld(`ACT_DATA, 0, 8'h01);
      wr(0, 1, 1);
      cmp(highAct, 8'h91);
      cmp(lowAct, 8'h62);
      ld(`ACT_CMD, 0, `CMD_RD_FUSE);
      rdb(0, 1, 8'hF1);
      progMode <= 1'b0;
      repeat (8) @(posedge mclk);
      cmp(lowAct, 8'h60);
      cmp(extAct, 8'hF1);
      progMode <= 1'b1;
      repeat (8) @(posedge mclk);
      ld(`ACT_CMD, 0, `CMD_WR_LOCK);
      ld(`ACT_DATA, 0, 8'hFE);
      wr(0, 0, 1);
      cmp(locks, 8'hFE);
      ld(`ACT_CMD, 0, `CMD_WR_FUSE);
      ld(`ACT_DATA, 0, 8'h00);
      wr(0, 0, 0);
      ld(`ACT_CMD, 0, `CMD_RD_SIG);
      ld(`ACT_ADDR, 0, 8'h01);
      rdb(0, 0, SIG[1]);
      ld(`ACT_CMD, 0, `CMD_ERASE);
      wr(0, 0, 1);
      cmp(locks, 8'hFF);
      ld(`ACT_CMD, 0, `CMD_RD_FUSE);
      rdb(0, 0, 8'h60);
      serialMode <= 1'b1;
      sSel <= 2'd3;
      sData <= 8'hFF;
      @(posedge mclk);
      serialFuseWrite <= 1'b1;
      @(posedge mclk);
      serialFuseWrite <= 1'b0;
      repeat (4) @(posedge mclk);
      cmp(serRd, 8'hFF);
      rdb(1, 1, 8'hDF);
      op(`OP_PAGE, `ACT_IDLE, 1'b1, 1'b0, 8'h00);
      report_and_stop;
   end
endmodule
